// ==== acd_cmd_core.sv ====
// acd_cmd_core: command decoder, register set, scan sequencer and result store
// for a 16-channel 12-bit converter.
// assumes: the analog front end takes conv_start_o with channel, pair, temp and
// averaging settings, and answers with conv_done_i and an offset-binary result.
//
// Overview of operation
// - bytes arrive msb first; leading 1, 01, 001, 0001 select the target register
// - conversion byte: bit 7 selector, bits 6..3 channel, 2..1 scan, 0 temperature
// - scan 00 converts 0..N, scan 01 converts N..top, one result each, outside clock mode 11
// - scan 10 repeats channel N, result count from the averaging register, outside clock mode 11
// - scan 11 converts channel N once only
// - temperature request adds one measurement, delivered first in the scan
// - clock modes 10/11 start on conversion write, 00/01 on start-pin low pulse
// - skip channels used as start pin or negative reference, and broken pairs
// - setup bits 5..4 clock mode, 3..2 reference, 1..0 pair addressing
// - pair field 10 stores next byte as unipolar, 11 as bipolar
// - pair field 00/01 leaves pair registers alone; next byte is a command
// - a pair enabled both ways is treated as unipolar
// - unipolar pairs give straight binary, bipolar pairs two's complement
// - averaging bit set averages up to 32 samples per result, every scan mode
// - clock mode 11 forces averaging off
// - reset byte bit 3 one clears results only, zero restores all defaults
// - all registers power up zero, except clock mode which starts at 10
// - bytes sampled on rising serial clock in a frame opening with a command
// - sixteen results plus one temperature; when full the oldest is overwritten
`timescale 1ns/10ps
`default_nettype none
module acd_cmd_core (
	// system clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// serial command link
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic din_i,
	// conversion-start pin, active low
	input wire logic convert_start_pin_n_i,
	// analog front end
	input wire logic conv_done_i,
	input wire logic [acd_pkg::RES_W-1:0] conv_result_i,
	output logic conv_start_o,
	output logic [acd_pkg::CHAN_W-1:0] conv_chan_o,
	output logic conv_diff_o,
	output logic conv_bipolar_o,
	output logic conv_temp_o,
	output logic [5:0] avg_samples_o,
	// configuration view
	output logic [1:0] clock_mode_o,
	output logic [1:0] vref_mode_o,
	output logic scan_busy_o,
	// result readout
	input wire logic rd_pop_i,
	output logic [15:0] rd_data_o,
	output logic rd_valid_o,
	output logic [4:0] fifo_count_o
);
	import acd_pkg::*;

	acd_rx_if rx ();

	logic byte_tgl_s;
	logic byte_tgl_d_r;
	logic convert_start_pin_s;
	logic convert_start_pin_d_r;
	logic byte_evt;
	logic [7:0] rx_byte;
	logic pair_expect_r;
	logic pair_bip_sel_r;
	logic [7:0] conversion_request_r;
	logic [7:0] setup_config_r;
	logic [7:0] averaging_config_r;
	logic [7:0] unipolar_pair_enable_r;
	logic [7:0] bipolar_pair_enable_r;
	logic wr_conv;
	logic wr_setup;
	logic wr_avg;
	logic wr_rst;
	logic wr_pair;
	logic soft_rst;
	logic fifo_clr;
	logic start_evt;
	acd_seq_e seq_r;
	logic [3:0] cur_ch_r;
	logic [3:0] last_ch_r;
	logic [4:0] reps_r;
	logic cur_temp_r;
	logic cur_bip_r;
	logic [3:0] start_ch;
	logic [1:0] scan_mode;
	logic [2:0] pair_idx;
	logic pair_uni;
	logic pair_bip;
	logic pair_on;
	logic ch_skip;
	logic ch_is_last;
	logic [5:0] avg_nxt;
	logic [RES_W-1:0] fifo_mem_r [FIFO_DEPTH];
	logic [3:0] wr_ptr_r;
	logic [3:0] rd_ptr_r;
	logic [4:0] count_r;
	logic [RES_W-1:0] temp_res_r;
	logic temp_valid_r;
	logic push;
	logic push_temp;
	logic pop_fifo;
	logic pop_temp;
	logic fifo_full;
	logic [RES_W-1:0] push_data;

	// serial receiver on the host's clock
	acd_spi_rx u_rx (
		.sclk_i(sclk_i),
		.cs_n_i(cs_n_i),
		.din_i(din_i),
		.rst_i(rst_i),
		.rx(rx.link)
	);

	// byte toggle and start pin both come from outside this clock domain
	acd_sync2 #(.W(2), .INIT(2'h1)) u_sync (
		.clk_i(sys_clk_i),
		.rst_i(rst_i),
		.d_i({rx.byte_tgl, convert_start_pin_n_i}),
		.q_o({byte_tgl_s, convert_start_pin_s})
	);

	// edge memories for the synchronised toggle and pin
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			byte_tgl_d_r <= 1'b0;
			convert_start_pin_d_r <= 1'b1;
		end else begin
			byte_tgl_d_r <= byte_tgl_s;
			convert_start_pin_d_r <= convert_start_pin_s;
		end
	end

	// byte data is stable by the time its toggle has crossed
	assign byte_evt = byte_tgl_s ^ byte_tgl_d_r;
	assign rx_byte = rx.byte_data;

	// command decode; a data byte only follows a pair setup in the same frame
	always_comb begin
		wr_conv = 1'b0;
		wr_setup = 1'b0;
		wr_avg = 1'b0;
		wr_rst = 1'b0;
		wr_pair = 1'b0;
		if (byte_evt) begin
			if (pair_expect_r && !rx.first_byte) begin
				wr_pair = 1'b1;
			end else if (rx_byte[7]) begin
				wr_conv = 1'b1;
			end else if (rx_byte[6]) begin
				wr_setup = 1'b1;
			end else if (rx_byte[5]) begin
				wr_avg = 1'b1;
			end else if (rx_byte[4]) begin
				wr_rst = 1'b1;
			end
		end
	end

	assign soft_rst = wr_rst && !rx_byte[RST_FIFO_BIT];
	assign fifo_clr = wr_rst; // a full reset empties the results as well

	// pair-write expectation, cleared by any other byte or a new frame
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || soft_rst) begin
			pair_expect_r <= 1'b0;
			pair_bip_sel_r <= 1'b0;
		end else if (byte_evt) begin
			pair_expect_r <= wr_setup && rx_byte[SETUP_PAIR_HI];
			if (wr_setup) begin
				pair_bip_sel_r <= rx_byte[SETUP_PAIR_LO];
			end
		end
	end

	// conversion register
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || soft_rst) begin
			conversion_request_r <= CONV_RESET;
		end else if (wr_conv) begin
			conversion_request_r <= rx_byte;
		end
	end

	// setup register; clock mode leaves reset at the write-started mode
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || soft_rst) begin
			setup_config_r <= SETUP_RESET;
		end else if (wr_setup) begin
			setup_config_r <= rx_byte;
		end
	end

	// averaging register
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || soft_rst) begin
			averaging_config_r <= AVG_RESET;
		end else if (wr_avg) begin
			averaging_config_r <= rx_byte;
		end
	end

	// pair registers, written only by the byte after a pair setup
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || soft_rst) begin
			unipolar_pair_enable_r <= PAIR_RESET;
			bipolar_pair_enable_r <= PAIR_RESET;
		end else if (wr_pair) begin
			if (pair_bip_sel_r) begin
				bipolar_pair_enable_r <= rx_byte;
			end else begin
				unipolar_pair_enable_r <= rx_byte;
			end
		end
	end

	// scan start: write in modes 10/11, falling start pin in modes 00/01
	always_comb begin
		start_evt = 1'b0;
		if (setup_config_r[SETUP_CLK_HI]) begin
			start_evt = wr_conv;
		end else begin
			start_evt = convert_start_pin_d_r && !convert_start_pin_s;
		end
	end

	// new conversion byte takes effect for the scan it starts
	assign start_ch = wr_conv ? rx_byte[CONV_CHAN_HI:CONV_CHAN_LO] :
		conversion_request_r[CONV_CHAN_HI:CONV_CHAN_LO];
	assign scan_mode = wr_conv ? rx_byte[CONV_SCAN_HI:CONV_SCAN_LO] :
		conversion_request_r[CONV_SCAN_HI:CONV_SCAN_LO];

	// pair lookup for the current channel; pair 0 sits in bit 7
	assign pair_idx = 3'h7 - cur_ch_r[3:1];
	assign pair_uni = unipolar_pair_enable_r[pair_idx];
	assign pair_bip = bipolar_pair_enable_r[pair_idx];
	assign pair_on = pair_uni || pair_bip;

	// skip pins lent to conversion start or negative reference, and broken pairs
	always_comb begin
		ch_skip = 1'b0;
		if (!setup_config_r[SETUP_CLK_HI] && cur_ch_r == CHAN_CONVERT_START_PIN) begin
			ch_skip = 1'b1;
		end
		if (setup_config_r[SETUP_REF_HI:SETUP_REF_LO] == VREF_EXT_DIFF &&
				cur_ch_r == CHAN_REFN) begin
			ch_skip = 1'b1;
		end
		if (pair_on && cur_ch_r[0]) begin
			ch_skip = 1'b1; // odd member is converted with its even partner
		end
		if (pair_on && cur_ch_r[3:1] == CHAN_REFN[3:1]) begin
			if (!setup_config_r[SETUP_CLK_HI] ||
					setup_config_r[SETUP_REF_HI:SETUP_REF_LO] == VREF_EXT_DIFF) begin
				ch_skip = 1'b1; // last pair ignored when a member is lent out
			end
		end
	end

	assign ch_is_last = cur_ch_r == last_ch_r;

	// samples per result; clock mode 11 forces a single sample
	always_comb begin
		avg_nxt = AVG_ONE;
		if (averaging_config_r[AVG_EN_BIT] &&
				setup_config_r[SETUP_CLK_HI:SETUP_CLK_LO] != CLK_WRITE_EXT) begin
			avg_nxt = AVG_BASE << averaging_config_r[AVG_SAMP_HI:AVG_SAMP_LO];
		end
	end

	// scan sequencer
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || soft_rst) begin
			seq_r <= SQ_IDLE;
			cur_ch_r <= CHAN_FIRST;
			last_ch_r <= CHAN_FIRST;
			reps_r <= 5'h00;
			cur_temp_r <= 1'b0;
			cur_bip_r <= 1'b0;
			conv_start_o <= 1'b0;
			conv_chan_o <= CHAN_FIRST;
			conv_diff_o <= 1'b0;
			conv_bipolar_o <= 1'b0;
			conv_temp_o <= 1'b0;
			avg_samples_o <= AVG_ONE;
		end else begin
			conv_start_o <= 1'b0;
			unique case (seq_r)
				SQ_IDLE: begin
					if (start_evt) begin
						reps_r <= 5'h01;
						cur_ch_r <= start_ch;
						last_ch_r <= start_ch;
						// the write-started externally clocked mode 11 does no scanning
						if (setup_config_r[SETUP_CLK_HI:SETUP_CLK_LO] != CLK_WRITE_EXT) begin
							unique case (scan_mode)
								SCAN_LOW_TO_N: cur_ch_r <= CHAN_FIRST;
								SCAN_N_TO_TOP: last_ch_r <= CHAN_MAX;
								SCAN_REPEAT: reps_r <= 5'((averaging_config_r[AVG_REP_HI:AVG_REP_LO]
									+ 2'h1) * REP_STEP);
								SCAN_SINGLE: reps_r <= 5'h01;
							endcase
						end
						if (wr_conv ? rx_byte[CONV_TEMP_BIT] :
								conversion_request_r[CONV_TEMP_BIT]) begin
							seq_r <= SQ_TEMP; // temperature goes first
						end else begin
							seq_r <= SQ_PICK;
						end
					end
				end
				SQ_TEMP: begin
					conv_start_o <= 1'b1;
					conv_temp_o <= 1'b1;
					conv_diff_o <= 1'b0;
					conv_bipolar_o <= 1'b0;
					avg_samples_o <= avg_nxt;
					cur_temp_r <= 1'b1;
					cur_bip_r <= 1'b0;
					seq_r <= SQ_WAIT;
				end
				SQ_PICK: begin
					if (ch_skip) begin
						if (ch_is_last) begin
							seq_r <= SQ_IDLE;
						end else begin
							cur_ch_r <= cur_ch_r + 4'h1;
						end
					end else begin
						conv_start_o <= 1'b1;
						conv_chan_o <= cur_ch_r;
						conv_temp_o <= 1'b0;
						conv_diff_o <= pair_on;
						conv_bipolar_o <= pair_bip && !pair_uni;
						avg_samples_o <= avg_nxt;
						cur_temp_r <= 1'b0;
						cur_bip_r <= pair_bip && !pair_uni;
						seq_r <= SQ_WAIT;
					end
				end
				SQ_WAIT: begin
					if (conv_done_i) begin
						if (cur_temp_r) begin
							seq_r <= SQ_PICK;
						end else if (reps_r > 5'h01) begin
							reps_r <= reps_r - 5'h01;
							seq_r <= SQ_PICK;
						end else if (ch_is_last) begin
							seq_r <= SQ_IDLE;
						end else begin
							cur_ch_r <= cur_ch_r + 4'h1;
							seq_r <= SQ_PICK;
						end
					end
				end
			endcase
		end
	end

	// result routing; bipolar offset-binary becomes two's complement by msb flip
	assign push = seq_r == SQ_WAIT && conv_done_i && !cur_temp_r;
	assign push_temp = seq_r == SQ_WAIT && conv_done_i && cur_temp_r;
	assign push_data = cur_bip_r ? {~conv_result_i[RES_W-1], conv_result_i[RES_W-2:0]} :
		conv_result_i;
	assign fifo_full = count_r == FIFO_FULL;
	assign pop_temp = rd_pop_i && temp_valid_r;
	assign pop_fifo = rd_pop_i && !temp_valid_r && count_r != 5'h00;

	// result store; a push into a full store drops the oldest entry
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			fifo_mem_r[wr_ptr_r] <= push_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || fifo_clr) begin
			wr_ptr_r <= 4'h0;
			rd_ptr_r <= 4'h0;
			count_r <= 5'h00;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 4'h1;
			end
			if (pop_fifo || (push && fifo_full)) begin
				rd_ptr_r <= rd_ptr_r + 4'h1; // overwrite oldest
			end
			if (push && !pop_fifo && !fifo_full) begin
				count_r <= count_r + 5'h01;
			end else if (pop_fifo && !push) begin
				count_r <= count_r - 5'h01;
			end
		end
	end

	// single temperature slot; a newer reading replaces an unread one
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			temp_res_r <= '0;
			temp_valid_r <= 1'b0;
		end else if (push_temp) begin
			temp_res_r <= conv_result_i;
			temp_valid_r <= 1'b1;
		end else if (fifo_clr || pop_temp) begin
			temp_valid_r <= 1'b0; // a reading landing with a clear is kept, set wins
		end
	end

	// read port; the temperature is always handed out before the other results
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rd_data_o <= 16'h0000;
			rd_valid_o <= 1'b0;
		end else begin
			rd_valid_o <= pop_temp || pop_fifo;
			if (pop_temp) begin
				rd_data_o <= {RES_PAD, temp_res_r};
			end else if (pop_fifo) begin
				rd_data_o <= {RES_PAD, fifo_mem_r[rd_ptr_r]};
			end else begin
				rd_data_o <= 16'h0000; // empty store reads zero
			end
		end
	end

	// configuration and status view
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			clock_mode_o <= CLK_WRITE_INT;
			vref_mode_o <= 2'h0;
			scan_busy_o <= 1'b0;
			fifo_count_o <= 5'h00;
		end else begin
			clock_mode_o <= setup_config_r[SETUP_CLK_HI:SETUP_CLK_LO];
			vref_mode_o <= setup_config_r[SETUP_REF_HI:SETUP_REF_LO];
			scan_busy_o <= seq_r != SQ_IDLE;
			fifo_count_o <= count_r;
		end
	end
endmodule // acd_cmd_core
`default_nettype wire

// ==== acd_pkg.sv ====
// acd_pkg: constants, field positions, reset values and types shared by the
// command decoder, its serial receiver and the port assertions.
// assumes: 16 analog channels, 12-bit results, sys_clk_i at 250 MHz.
package acd_pkg;

	// byte framing
	localparam int BYTE_W = 8;
	localparam logic [2:0] BIT_CNT_LAST = 3'h7;

	// channel space
	localparam int CHAN_W = 4;
	localparam logic [3:0] CHAN_MAX = 4'hf;
	localparam logic [3:0] CHAN_FIRST = 4'h0;
	localparam logic [3:0] CHAN_CONVERT_START_PIN = 4'hf; // shared with conversion-start pin
	localparam logic [3:0] CHAN_REFN = 4'he; // shared with negative reference

	// conversion byte fields
	localparam int CONV_CHAN_HI = 6;
	localparam int CONV_CHAN_LO = 3;
	localparam int CONV_SCAN_HI = 2;
	localparam int CONV_SCAN_LO = 1;
	localparam int CONV_TEMP_BIT = 0;

	// setup byte fields
	localparam int SETUP_CLK_HI = 5;
	localparam int SETUP_CLK_LO = 4;
	localparam int SETUP_REF_HI = 3;
	localparam int SETUP_REF_LO = 2;
	localparam int SETUP_PAIR_HI = 1;
	localparam int SETUP_PAIR_LO = 0;

	// averaging byte fields
	localparam int AVG_EN_BIT = 4;
	localparam int AVG_SAMP_HI = 3;
	localparam int AVG_SAMP_LO = 2;
	localparam int AVG_REP_HI = 1;
	localparam int AVG_REP_LO = 0;

	// reset byte field
	localparam int RST_FIFO_BIT = 3;

	// power-up values
	localparam logic [7:0] CONV_RESET = 8'h00;
	localparam logic [7:0] SETUP_RESET = 8'h20;
	localparam logic [7:0] AVG_RESET = 8'h00;
	localparam logic [7:0] PAIR_RESET = 8'h00;

	// clock modes, scan modes and reference modes
	localparam logic [1:0] CLK_CONVERT_START_PIN_INT = 2'h0;
	localparam logic [1:0] CLK_CONVERT_START_PIN_EXT = 2'h1;
	localparam logic [1:0] CLK_WRITE_INT = 2'h2;
	localparam logic [1:0] CLK_WRITE_EXT = 2'h3;
	localparam logic [1:0] SCAN_LOW_TO_N = 2'h0;
	localparam logic [1:0] SCAN_N_TO_TOP = 2'h1;
	localparam logic [1:0] SCAN_REPEAT = 2'h2;
	localparam logic [1:0] SCAN_SINGLE = 2'h3;
	localparam logic [1:0] VREF_EXT_DIFF = 2'h3;

	// averaging and repeat counts
	localparam logic [5:0] AVG_ONE = 6'h01;
	localparam logic [5:0] AVG_BASE = 6'h04; // shifted left by the sample-count field
	localparam logic [4:0] REP_STEP = 5'h04; // results = (field + 1) * step

	// result store
	localparam int RES_W = 12;
	localparam int FIFO_DEPTH = 16;
	localparam logic [4:0] FIFO_FULL = 5'h10;
	localparam logic [3:0] RES_PAD = 4'h0;

	typedef enum logic [2:0] {
		SQ_IDLE,
		SQ_TEMP,
		SQ_PICK,
		SQ_WAIT
	} acd_seq_e;

endpackage

// ==== acd_rx_if.sv ====
// acd_rx_if: carries each received byte from the serial clock domain
// into the system clock domain.
// assumes: byte_data and first_byte are held stable while byte_tgl settles.
`timescale 1ns/10ps
`default_nettype none
interface acd_rx_if;
	logic [7:0] byte_data; // last complete byte, msb received first
	logic first_byte; // byte was the first of its chip-select frame
	logic byte_tgl; // toggles once per completed byte

	modport link (output byte_data, output first_byte, output byte_tgl);
	modport core (input byte_data, input first_byte, input byte_tgl);
endinterface
`default_nettype wire

// ==== acd_sync2.sv ====
// acd_sync2: two-flop synchroniser for levels entering sys_clk_i.
// assumes: each bit is a level or a toggle, never a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
module acd_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// level in and out
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	// first stage is read only by the second stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= INIT;
			q_o <= INIT;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule // acd_sync2
`default_nettype wire

// ==== acd_spi_rx.sv ====
// acd_spi_rx: serial shifter on the host's serial clock.
// assumes: the serial clock only runs while chip select is low; a high
// chip select restarts the byte count, so a partial byte is dropped.
`timescale 1ns/10ps
`default_nettype none
module acd_spi_rx (
	// serial link
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic din_i,
	// system reset, used only to give the hand-off byte, first flag and toggle known values
	input wire logic rst_i,
	// byte hand-off
	acd_rx_if.link rx
);
	import acd_pkg::*;

	logic [6:0] shift_r;
	logic [2:0] bit_cnt_r;
	logic first_r;

	// bit capture on rising edges; chip select high restarts the frame
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			shift_r <= 7'h00;
			bit_cnt_r <= 3'h0;
			first_r <= 1'b1;
		end else begin
			shift_r <= {shift_r[5:0], din_i}; // msb first
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (bit_cnt_r == BIT_CNT_LAST) begin
				first_r <= 1'b0; // later bytes of the frame follow the command
			end
		end
	end

	// hand-off holds until the next byte, eight clocks later, long enough to cross
	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			rx.byte_data <= 8'h00;
			rx.first_byte <= 1'b1;
			rx.byte_tgl <= 1'b0;
		end else if (!cs_n_i && bit_cnt_r == BIT_CNT_LAST) begin
			rx.byte_data <= {shift_r, din_i};
			rx.first_byte <= first_r;
			rx.byte_tgl <= ~rx.byte_tgl;
		end
	end
endmodule // acd_spi_rx
`default_nettype wire

// ==== acd_chk.sv ====
// acd_chk: port assertions for the command core.
// assumes: bound to acd_cmd_core, one system clock domain.
`timescale 1ns/10ps
`default_nettype none
module acd_chk
	import acd_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// front end and configuration
	input wire logic conv_done_i,
	input wire logic conv_start_o,
	input wire logic [3:0] conv_chan_o,
	input wire logic conv_diff_o,
	input wire logic conv_bipolar_o,
	input wire logic conv_temp_o,
	input wire logic [5:0] avg_samples_o,
	input wire logic [1:0] clock_mode_o,
	input wire logic scan_busy_o,
	// readout
	input wire logic rd_pop_i,
	input wire logic [15:0] rd_data_o,
	input wire logic rd_valid_o,
	input wire logic [4:0] fifo_count_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// a conversion needs a done and a pick step before the next start
	a_start_gap: assert property (conv_start_o |=> !conv_start_o [*2])
		else $error("start pulses too close");
	a_done_next: assert property (conv_done_i && scan_busy_o |->
		##[2:5] (conv_start_o || !scan_busy_o)) else $error("no start after done");
	a_busy_start: assert property ($rose(scan_busy_o) |->
		##[0:2] (conv_start_o || !scan_busy_o)) else $error("scan without conversion");
	a_mode_avg: assert property (conv_start_o && clock_mode_o == CLK_WRITE_EXT |->
		avg_samples_o == AVG_ONE) else $error("averaging in mode 11");
	a_avg_set: assert property (conv_start_o |->
		avg_samples_o inside {6'h01, 6'h04, 6'h08, 6'h10, 6'h20}) else $error("bad sample count");
	a_temp_plain: assert property (conv_start_o && conv_temp_o |->
		!conv_diff_o && !conv_bipolar_o) else $error("temperature as pair");
	a_bip_pair: assert property (conv_bipolar_o |-> conv_diff_o)
		else $error("bipolar single-ended");
	// the start pin owns the top channel in modes 00 and 01
	a_pin_skip: assert property (conv_start_o && !conv_temp_o && !clock_mode_o[1] |->
		conv_chan_o != CHAN_CONVERT_START_PIN && !(conv_diff_o && conv_chan_o == CHAN_REFN))
		else $error("start pin channel converted");
	a_rd_cause: assert property (rd_valid_o |-> $past(rd_pop_i))
		else $error("read without pop");
	a_rd_quiet: assert property (!rd_valid_o |-> rd_data_o == 16'h0000)
		else $error("read data not quiet");
	a_count_cap: assert property (fifo_count_o <= FIFO_FULL)
		else $error("store over depth");
	a_reset_vals: assert property ($fell(rst_i) |-> clock_mode_o == CLK_WRITE_INT &&
		avg_samples_o == AVG_ONE && fifo_count_o == 5'h00) else $error("bad reset values");
	c_temp: cover property (conv_start_o && conv_temp_o);
	c_bip: cover property (conv_start_o && conv_bipolar_o);
	c_full: cover property (fifo_count_o == FIFO_FULL);
endmodule // acd_chk
bind acd_cmd_core acd_chk i_acd_chk (.sys_clk_i, .rst_i, .conv_done_i, .conv_start_o,
	.conv_chan_o, .conv_diff_o, .conv_bipolar_o, .conv_temp_o, .avg_samples_o,
	.clock_mode_o, .scan_busy_o, .rd_pop_i, .rd_data_o, .rd_valid_o, .fifo_count_o);
`default_nettype wire

// ==== acd_host_model.sv ====
// acd_host_model: serial host shifting command bytes into the core.
// assumes: link clock of 6 ns that stands low between frames.
`timescale 1ns/10ps
`default_nettype none
module acd_host_model (
	// serial link
	output logic sclk_o,
	output logic cs_n_o,
	output logic din_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end
	// n bits msb first in one select window; the odd offset keeps phase unrelated
	task automatic send(input logic [15:0] d, input int n);
		#1.3 cs_n_o = 1'b0;
		for (int k = 0; k < n; k++) begin
			din_o = d[15 - k];
			#3 sclk_o = 1'b1;
			#3 sclk_o = 1'b0;
		end
		#3 cs_n_o = 1'b1;
		din_o = ~din_o; // released line shows no stale bit
		#3;
	endtask
endmodule // acd_host_model
`default_nettype wire

// ==== tb_top.sv ====
// tb_top: self-checking bench for the command core.
// assumes: host model on the link, front end modelled here.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import acd_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic sclk_i, cs_n_i, din_i;
	logic convert_start_pin_n_i = 1'b1;
	logic conv_done_i = 1'b0;
	logic [11:0] conv_result_i = 12'h000;
	logic rd_pop_i = 1'b0;
	logic conv_start_o, conv_diff_o, conv_bipolar_o, conv_temp_o, scan_busy_o, rd_valid_o;
	logic [3:0] conv_chan_o;
	logic [5:0] avg_samples_o;
	logic [1:0] clock_mode_o, vref_mode_o;
	logic [1:0] fe_cnt = 2'h0;
	logic [15:0] rd_data_o;
	logic [4:0] fifo_count_o;
	int fails = 0;
	int comparisons = 0;
	int i;

	always #2 sys_clk_i = ~sys_clk_i;

	acd_host_model i_acd_host_model (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i));
	acd_cmd_core i_acd_cmd_core (.sys_clk_i, .rst_i, .sclk_i, .cs_n_i, .din_i,
		.convert_start_pin_n_i, .conv_done_i, .conv_result_i, .conv_start_o, .conv_chan_o,
		.conv_diff_o, .conv_bipolar_o, .conv_temp_o, .avg_samples_o, .clock_mode_o,
		.vref_mode_o, .scan_busy_o, .rd_pop_i, .rd_data_o, .rd_valid_o, .fifo_count_o);

	// front end: done four cycles after start, result tagged with the channel
	always @(posedge sys_clk_i) begin
		conv_done_i <= (fe_cnt == 2'h1);
		if (conv_start_o)
			fe_cnt <= 2'h3;
		else if (fe_cnt != 2'h0)
			fe_cnt <= fe_cnt - 2'h1;
		if (fe_cnt == 2'h1) begin
			conv_result_i <= conv_temp_o ? 12'h7c1 : {conv_chan_o, 8'h5a};
		end
	end

	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// wait for the write to land and any scan to finish, bounded
	task automatic idle();
		repeat (8) @(posedge sys_clk_i);
		for (int k = 0; k < 500 && scan_busy_o !== 1'b0; k++) @(posedge sys_clk_i);
		repeat (3) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic wr(input logic [15:0] d, input int n);
		i_acd_host_model.send(d, n);
		idle();
	endtask
	// low pulse long enough for the two-flop synchroniser
	task automatic pin();
		@(posedge sys_clk_i) convert_start_pin_n_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		convert_start_pin_n_i <= 1'b1;
		idle();
	endtask
	task automatic pop(input logic v, input logic [15:0] e);
		@(posedge sys_clk_i) rd_pop_i <= 1'b1;
		@(posedge sys_clk_i) rd_pop_i <= 1'b0;
		#1;
		chk("rd_valid", {15'h0, rd_valid_o}, {15'h0, v});
		chk("rd_data", rd_data_o, e);
	endtask
	task automatic cnt(input logic [4:0] e);
		chk("fifo_count", {11'h0, fifo_count_o}, {11'h0, e});
	endtask
	task automatic mode(input logic [1:0] e);
		chk("clock_mode", {14'h0, clock_mode_o}, {14'h0, e});
	endtask
	task automatic results();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// watchdog: the tests need under a thousand cycles
	initial begin
		repeat (30000) @(posedge sys_clk_i);
		fails++;
		results();
	end

	initial begin
		// three edges of reset, also clearing the link toggle
		repeat (3) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#1;
		mode(2'h2);
		chk("avg_samples", {10'h0, avg_samples_o}, 16'h0001);
		cnt(5'h00);
		$display("test defaults done");
		wr(16'h9900, 8);
		cnt(5'h04);
		pop(1'b1, 16'h07c1);
		for (i = 0; i < 4; i++) pop(1'b1, {4'h0, i[3:0], 8'h5a});
		wr(16'he200, 8);
		for (i = 12; i < 16; i++) pop(1'b1, {4'h0, i[3:0], 8'h5a});
		pop(1'b0, 16'h0000);
		$display("test scans done");
		wr(16'h3a00, 8);
		wr(16'hac00, 8);
		cnt(5'h0c);
		chk("avg_samples", {10'h0, avg_samples_o}, 16'h0010);
		wr(16'h3b00, 8);
		wr(16'hac00, 8);
		cnt(5'h10);
		wr(16'h1800, 8);
		cnt(5'h00);
		wr(16'hae00, 8);
		cnt(5'h01);
		pop(1'b1, 16'h055a);
		$display("test repeat done");
		wr(16'h6280, 16);
		wr(16'h63c0, 16);
		wr(16'h9000, 8);
		pop(1'b1, 16'h005a);
		pop(1'b1, 16'h0a5a);
		wr(16'h6196, 16);
		cnt(5'h01);
		pop(1'b1, 16'h0a5a);
		$display("test pairs done");
		wr(16'h1000, 8);
		mode(2'h2);
		wr(16'h4000, 8);
		mode(2'h0);
		wr(16'h8800, 8);
		cnt(5'h00);
		pin();
		cnt(5'h02);
		pop(1'b1, 16'h005a);
		pop(1'b1, 16'h015a);
		wr(16'hf200, 8);
		pin();
		cnt(5'h01);
		pop(1'b1, 16'h0e5a);
		$display("test start_pin done");
		wr(16'h7c00, 8);
		chk("vref_mode", {14'h0, vref_mode_o}, 16'h0003);
		wr(16'h3000, 8);
		wr(16'h9800, 8);
		cnt(5'h01);
		pop(1'b1, 16'h035a);
		chk("avg_samples", {10'h0, avg_samples_o}, 16'h0001);
		wr(16'hf600, 8);
		cnt(5'h00);
		wr(16'h0500, 8);
		mode(2'h3);
		cnt(5'h00);
		$display("test mode11 done");
		results();
	end
endmodule // tb_top
`default_nettype wire
